// ==== rtl/tpsc_regs.vh ====
// tpsc_regs.vh: register indices, field positions and reset values of the
// shared prescaler and per-channel clock select block.
// assumes: included by its bare name; byte address is four times an index.
`ifndef TPSC_REGS_VH
`define TPSC_REGS_VH

`define TPSC_IDX_MODE0 20'hF0190
`define TPSC_IDX_MODE_STEP 20'h00002
`define TPSC_IDX_MODE7 20'hF019E
`define TPSC_IDX_PRESCALE 20'hF01B6
`define TPSC_IDX_ROUTING 20'hF01C0

`define TPSC_SEL_MODE0 4'h0
`define TPSC_SEL_PRESCALE 4'h8
`define TPSC_SEL_ROUTING 4'h9
`define TPSC_SEL_NONE 4'hF

`define TPSC_PRESCALE_RESET 16'h0000
`define TPSC_MODE_RESET 16'h0000
`define TPSC_ROUTING_RESET 8'h00
`define TPSC_ROUTING_MASK 8'hE3

`define TPSC_PRS_A_LSB 0
`define TPSC_PRS_B_LSB 4
`define TPSC_PRS_C_LSB 8
`define TPSC_PRS_D_LSB 12

`define TPSC_MODE_CKS_LSB 14
`define TPSC_MODE_CCS_BIT 12
`define TPSC_MODE_B11_BIT 11
`define TPSC_MODE_EDGE_LSB 6
`define TPSC_B11_CHANNELS 8'h5E

`define TPSC_CKS_A 2'b00
`define TPSC_CKS_C 2'b01
`define TPSC_CKS_B 2'b10
`define TPSC_CKS_D 2'b11

`define TPSC_EDGE_FALL 2'b00
`define TPSC_EDGE_RISE 2'b01

`define TPSC_HTRANS_NONSEQ 2'b10
`define TPSC_HSIZE_WORD 3'b010

`endif

// ==== rtl/tpsc_top.v ====
// tpsc_top.v: shared prescaler, four common operation clock pulses and the
// per-channel operation/count clock selection of an eight-channel timer unit.
// assumes: one 10 MHz clock mclk, AHB-Lite single word transfers, timer input
// pins already synchronous to mclk.
`timescale 1ns/1ps
`include "tpsc_regs.vh"

module tpsc_top (
  input wire mclk,
  input wire rst_n,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  input wire [7:0] timer_input_pin,
  input wire [7:0] routed_input,
  output reg common_clock_a,
  output reg common_clock_b,
  output reg common_clock_c,
  output reg common_clock_d,
  output reg [7:0] op_clock,
  output reg [7:0] count_clock
);

  // pulse when the low r bits of the counter are all ones; r = 0 is every cycle
  function pulse_of;
    input [15:0] cnt;
    input [3:0] r;
    reg [15:0] mask;
    begin
      mask = (16'h0001 << r) - 16'h0001;
      pulse_of = &(cnt | ~mask);
    end
  endfunction

  // operation clock chosen by a channel's two select bits
  function op_pick;
    input [1:0] code;
    input wide_ok;
    input [3:0] pulses;
    begin
      case (code)
        `TPSC_CKS_A: op_pick = pulses[0];
        `TPSC_CKS_B: op_pick = pulses[1];
        `TPSC_CKS_C: op_pick = wide_ok & pulses[2];
        `TPSC_CKS_D: op_pick = wide_ok & pulses[3];
        default: op_pick = 1'b0;
      endcase
    end
  endfunction

  // valid input edge as picked by the two edge select bits
  function edge_ok;
    input [1:0] sel;
    input rise;
    input fall;
    begin
      case (sel)
        `TPSC_EDGE_FALL: edge_ok = fall;
        `TPSC_EDGE_RISE: edge_ok = rise;
        default: edge_ok = rise | fall;
      endcase
    end
  endfunction

  // divider exponent of the third common clock: 2, 4, 16 or 64
  function [3:0] shift_c;
    input [1:0] code;
    begin
      case (code)
        2'b00: shift_c = 4'h1;
        2'b01: shift_c = 4'h2;
        2'b10: shift_c = 4'h4;
        2'b11: shift_c = 4'h6;
        default: shift_c = 4'h1;
      endcase
    end
  endfunction

  // divider exponent of the fourth common clock: 256 up to 16384
  function [3:0] shift_d;
    input [1:0] code;
    begin
      case (code)
        2'b00: shift_d = 4'h8;
        2'b01: shift_d = 4'hA;
        2'b10: shift_d = 4'hC;
        2'b11: shift_d = 4'hE;
        default: shift_d = 4'h8;
      endcase
    end
  endfunction

  // register select from a byte address; index times four is the byte address
  function [3:0] reg_sel;
    input [31:0] addr;
    reg [3:0] s;
    integer i;
    begin
      s = `TPSC_SEL_NONE;
      if (addr[1:0] == 2'b00 && addr[31:22] == 10'h000) begin
        for (i = 0; i < 8; i = i + 1) begin
          if (addr[21:2] == `TPSC_IDX_MODE0 + i[19:0] * `TPSC_IDX_MODE_STEP) begin
            s = i[3:0];
          end
        end
        if (addr[21:2] == `TPSC_IDX_PRESCALE) begin
          s = `TPSC_SEL_PRESCALE;
        end
        if (addr[21:2] == `TPSC_IDX_ROUTING) begin
          s = `TPSC_SEL_ROUTING;
        end
      end
      reg_sel = s;
    end
  endfunction

  localparam [7:0] bit11_kept = `TPSC_B11_CHANNELS;

  reg [15:0] prescale_q;
  wire [127:0] mode_all;
  reg [7:0] routing_q;
  reg [15:0] div_cnt_q;
  reg wr_pend_q;
  reg rd_pend_q;
  reg [3:0] sel_q;
  reg [7:0] sample_q;
  reg [3:0] r_c;
  reg [3:0] r_d;
  wire pulse_a;
  wire pulse_b;
  wire pulse_c;
  wire pulse_d;
  wire [3:0] pulse_set;
  wire take;
  wire word_ok;
  wire [7:0] mck_d;
  wire [7:0] cclk_d;
  reg [7:0] pin_sel;
  wire [9:0] wr_hit;
  reg [15:0] rd_word_d;

  // single free-running counter shared by all pulse generators
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt_q <= 16'h0000;
    end else begin
      div_cnt_q <= div_cnt_q + 16'h0001;
    end
  end

  always @* begin
    r_c = shift_c(prescale_q[`TPSC_PRS_C_LSB +: 2]);
    r_d = shift_d(prescale_q[`TPSC_PRS_D_LSB +: 2]);
  end

  assign pulse_a = pulse_of(div_cnt_q, prescale_q[`TPSC_PRS_A_LSB +: 4]);
  assign pulse_b = pulse_of(div_cnt_q, prescale_q[`TPSC_PRS_B_LSB +: 4]);
  assign pulse_c = pulse_of(div_cnt_q, r_c);
  assign pulse_d = pulse_of(div_cnt_q, r_d);
  assign pulse_set = {pulse_d, pulse_c, pulse_b, pulse_a};

  // one flop per common clock so each output comes straight from a register
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      common_clock_a <= 1'b0;
    end else begin
      common_clock_a <= pulse_a;
    end
  end

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      common_clock_b <= 1'b0;
    end else begin
      common_clock_b <= pulse_b;
    end
  end

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      common_clock_c <= 1'b0;
    end else begin
      common_clock_c <= pulse_c;
    end
  end

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      common_clock_d <= 1'b0;
    end else begin
      common_clock_d <= pulse_d;
    end
  end

  // per-channel operation clock, input choice and valid edge detection
  genvar n;
  generate
    for (n = 0; n < 8; n = n + 1) begin : g_chan
      localparam [3:0] chan_sel = n;
      localparam [15:0] wr_keep = bit11_kept[n] ? 16'hFFFF : ~(16'h0001 << `TPSC_MODE_B11_BIT);
      reg [15:0] mode_ch_q;
      reg cclk;
      wire [15:0] m = mode_ch_q;
      wire pin_now = pin_sel[n];
      wire rise = pin_now & ~sample_q[n];
      wire fall = ~pin_now & sample_q[n];
      wire may_use_cd = (n == 1) || (n == 3);
      wire mck = op_pick(m[`TPSC_MODE_CKS_LSB +: 2], may_use_cd, pulse_set);
      wire valid = edge_ok(m[`TPSC_MODE_EDGE_LSB +: 2], rise, fall);

      // a fixed bit 11 is masked on the way in, so it reads back as zero
      always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          mode_ch_q <= `TPSC_MODE_RESET;
        end else if (wr_hit[n]) begin
          mode_ch_q <= hwdata[15:0] & wr_keep;
        end
      end

      // edge detector runs on the operation clock
      always @* begin
        if (m[`TPSC_MODE_CCS_BIT]) begin
          cclk = mck & valid;
        end else begin
          cclk = mck;
        end
      end

      assign wr_hit[n] = wr_pend_q && (sel_q == chan_sel);
      assign mode_all[n*16 +: 16] = mode_ch_q;
      assign mck_d[n] = mck;
      assign cclk_d[n] = cclk;
    end
  endgenerate

  always @* begin
    pin_sel = (routing_q & `TPSC_ROUTING_MASK & routed_input) |
              (~(routing_q & `TPSC_ROUTING_MASK) & timer_input_pin);
  end

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sample_q <= 8'h00;
      op_clock <= 8'h00;
      count_clock <= 8'h00;
    end else begin
      sample_q <= (mck_d & pin_sel) | (~mck_d & sample_q);
      op_clock <= mck_d;
      count_clock <= cclk_d;
    end
  end

  // AHB-Lite slave: writes zero-wait, reads take one wait state
  assign take = hsel && hready && (htrans == `TPSC_HTRANS_NONSEQ);
  assign word_ok = (hsize == `TPSC_HSIZE_WORD);

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wr_pend_q <= 1'b0;
    end else begin
      wr_pend_q <= take && hwrite && word_ok;
    end
  end

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sel_q <= `TPSC_SEL_NONE;
    end else if (take) begin
      sel_q <= reg_sel(haddr);
    end
  end

  // the read wait lets a write just ahead of it land before the word is taken
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rd_pend_q <= 1'b0;
      hreadyout <= 1'b1;
    end else begin
      rd_pend_q <= take && !hwrite;
      hreadyout <= !(take && !hwrite);
    end
  end

  // every transfer is answered okay
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      hresp <= 1'b0;
    end else begin
      hresp <= 1'b0;
    end
  end

  // prescaler and routing registers; mode registers live in g_chan
  assign wr_hit[`TPSC_SEL_PRESCALE] = wr_pend_q && (sel_q == `TPSC_SEL_PRESCALE);
  assign wr_hit[`TPSC_SEL_ROUTING] = wr_pend_q && (sel_q == `TPSC_SEL_ROUTING);

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      prescale_q <= `TPSC_PRESCALE_RESET;
    end else if (wr_hit[`TPSC_SEL_PRESCALE]) begin
      prescale_q <= hwdata[15:0];
    end
  end

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      routing_q <= `TPSC_ROUTING_RESET;
    end else if (wr_hit[`TPSC_SEL_ROUTING]) begin
      routing_q <= hwdata[7:0] & `TPSC_ROUTING_MASK;
    end
  end

  // read multiplexer; unmapped words read as zero
  always @* begin
    rd_word_d = 16'h0000;
    case (sel_q)
      `TPSC_SEL_PRESCALE: rd_word_d = prescale_q;
      `TPSC_SEL_ROUTING: rd_word_d = {8'h00, routing_q};
      default: begin
        if (sel_q < `TPSC_SEL_PRESCALE) begin
          rd_word_d = mode_all[sel_q[2:0]*16 +: 16];
        end
      end
    endcase
  end

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      hrdata <= 32'h00000000;
    end else if (rd_pend_q) begin
      hrdata <= {16'h0000, rd_word_d};
    end
  end

endmodule // tpsc_top

// ==== test/tpsc_top_sva.sv ====
// tpsc_top_sva.sv: port checker for the prescaler and clock select block.
// assumes: bound to tpsc_top, hready tied to hreadyout.
`timescale 1ns/1ps
module tpsc_chk (
  input wire mclk,
  input wire rst_n,
  input wire hsel,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire hready,
  input wire [31:0] hrdata,
  input wire hreadyout,
  input wire hresp,
  input wire common_clock_c,
  input wire common_clock_d,
  input wire [7:0] op_clock,
  input wire [7:0] count_clock
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  wire take = hsel && hready && htrans == 2'b10;
  read_wait_a: assert property (take && !hwrite |=> !hreadyout)
    else $error("read data phase without wait");
  write_nowait_a: assert property (take && hwrite |=> hreadyout)
    else $error("write data phase stalled");
  wait_once_a: assert property (!hreadyout |=> hreadyout)
    else $error("wait longer than one cycle");
  resp_okay_a: assert property (hresp == 1'b0)
    else $error("response not okay");
  upper_zero_a: assert property (hreadyout |-> hrdata[31:16] == 16'h0000)
    else $error("upper read bits set");
  count_gate_a: assert property ((count_clock & ~op_clock) == 8'h00)
    else $error("count pulse outside op pulse");
  c_single_a: assert property (common_clock_c |=> !common_clock_c)
    else $error("clock c pulse too wide");
  d_gap_a: assert property (common_clock_d |=> !common_clock_d [*8])
    else $error("clock d pulses too close");
  d_in_c_a: assert property (common_clock_d |-> common_clock_c)
    else $error("clock d off the shared count");
  cover property (take && !hwrite);
  cover property (common_clock_d);
  cover property (count_clock[2]);
endmodule // tpsc_chk
bind tpsc_top tpsc_chk tpsc_chk_inst (.mclk(mclk), .rst_n(rst_n), .hsel(hsel),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .common_clock_c(common_clock_c),
  .common_clock_d(common_clock_d), .op_clock(op_clock), .count_clock(count_clock));

// ==== test/tpsc_top_tb_top.sv ====
// tpsc_top_tb_top.sv: self-checking bench for the prescaler and clock select.
// assumes: tpsc_top and tpsc_top_sva.sv compiled alongside.
`timescale 1ns/1ps
`include "tpsc_regs.vh"
module tpsc_top_tb_top;
  logic mclk = 0;
  logic rst_n = 0;
  logic hsel = 0;
  logic hwrite = 0;
  logic [31:0] haddr = 0;
  logic [31:0] hwdata = 0;
  logic [31:0] hrdata;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 3'h2;
  logic [7:0] pin = 0;
  logic [7:0] rin = 0;
  logic [7:0] op_clock;
  logic [7:0] count_clock;
  logic hreadyout, hresp, ca, cb, cc, cd;
  int mismatches = 0;
  int checked = 0;
  wire [19:0] lanes = {count_clock, op_clock, cd, cc, cb, ca};
  tpsc_top tpsc_top_inst (.mclk(mclk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .timer_input_pin(pin), .routed_input(rin), .common_clock_a(ca),
    .common_clock_b(cb), .common_clock_c(cc), .common_clock_d(cd),
    .op_clock(op_clock), .count_clock(count_clock));
  initial forever #50 mclk = ~mclk;  // source never changes mid-run
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic [19:0] md(input logic [2:0] n);
    return `TPSC_IDX_MODE0 + {16'h0000, n, 1'b0};
  endfunction
  // one single word transfer; hold each phase until hready is sampled high
  task automatic xfer(input logic [19:0] i, input logic w, input logic [15:0] d,
                      output logic [31:0] r);
    @(posedge mclk);
    hsel <= 1'b1;
    haddr <= {10'h000, i, 2'b00};
    hwrite <= w;
    htrans <= 2'b10;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= {16'h0000, d};
    do @(posedge mclk); while (hreadyout !== 1'b1);
    r = hrdata;
    hsel <= 1'b0;
  endtask
  task automatic wr(input logic [19:0] i, input logic [15:0] d);
    logic [31:0] r;
    xfer(i, 1'b1, d, r);
  endtask
  task automatic rd(input logic [19:0] i, input logic [31:0] e);
    logic [31:0] r;
    xfer(i, 1'b0, 16'h0000, r);
    chk(r, e);
  endtask
  // cycles from one pulse of a lane to its next
  task automatic period(input int l, input int e);
    int n;
    n = 0;
    repeat (3) @(posedge mclk);
    while (lanes[l] !== 1'b1 && n < 70000) begin
      @(posedge mclk);
      n++;
    end
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (lanes[l] !== 1'b1 && n < 70000);
    chk(n, e);
  endtask
  task automatic t_reset;
    rd(`TPSC_IDX_PRESCALE, 32'h0);
    rd(`TPSC_IDX_MODE7, 32'h0);
    rd(20'hF01A0, 32'h0);
  endtask
  task automatic t_regs;
    wr(`TPSC_IDX_PRESCALE, 16'h3377);
    rd(`TPSC_IDX_PRESCALE, 32'h3377);
    wr(md(0), 16'hFFFF);
    rd(md(0), 32'hF7FF);
    wr(md(2), 16'h0800);
    rd(md(2), 32'h0800);
    wr(md(1), 16'h0800);
    rd(md(1), 32'h0800);
    wr(md(0), 16'h0000);
    wr(md(1), 16'h0000);
  endtask
  task automatic t_divs;
    wr(`TPSC_IDX_PRESCALE, 16'h0010);
    fork period(0, 1); period(1, 2); period(2, 2); period(3, 256); join
    wr(`TPSC_IDX_PRESCALE, 16'h314F);
    fork period(0, 32768); period(1, 16); period(2, 4); period(3, 16384); join
    wr(`TPSC_IDX_PRESCALE, 16'h2232);
    fork period(0, 4); period(1, 8); period(2, 16); period(3, 4096); join
    wr(`TPSC_IDX_PRESCALE, 16'h1375);
    fork period(0, 32); period(1, 128); period(2, 64); period(3, 1024); join
  endtask
  task automatic t_select;
    int e[4] = '{1, 2, 4, 256};
    int h;
    h = 0;
    wr(`TPSC_IDX_PRESCALE, 16'h0020);
    for (int k = 0; k < 4; k++) begin
      wr(md(1), {k[1:0], 14'h0000});
      fork period(5, e[k]); period(13, e[k]); join
    end
    wr(md(0), 16'hC000);
    repeat (3) @(posedge mclk);
    repeat (300) begin
      @(posedge mclk);
      if (op_clock[0] !== 1'b0) h++;
    end
    chk(h, 0);
    wr(md(0), 16'h8000);
    period(4, 4);
  endtask
  // move one input of channel c (routed or pin) and count its count pulses
  task automatic edge_cnt(input int c, input logic v, input logic alt, input int e);
    int h;
    h = 0;
    @(posedge mclk);
    if (alt)
      rin <= v ? (rin | (8'h01 << c)) : (rin & ~(8'h01 << c));
    else
      pin <= v ? (pin | (8'h01 << c)) : (pin & ~(8'h01 << c));
    repeat (8) begin
      @(posedge mclk);
      if (count_clock[c] === 1'b1) h++;
    end
    chk(h, e);
  endtask
  task automatic t_count;
    wr(md(2), 16'h1040);
    edge_cnt(2, 1'b1, 1'b0, 1);
    edge_cnt(2, 1'b0, 1'b0, 0);
    wr(md(2), 16'h1000);
    edge_cnt(2, 1'b1, 1'b0, 0);
    edge_cnt(2, 1'b0, 1'b0, 1);
  endtask
  task automatic t_route;
    wr(`TPSC_IDX_ROUTING, 16'h00FF);
    rd(`TPSC_IDX_ROUTING, 32'hE3);
    wr(md(0), 16'h1040);
    edge_cnt(0, 1'b1, 1'b1, 1);
    edge_cnt(0, 1'b1, 1'b0, 0);
    edge_cnt(2, 1'b1, 1'b1, 0);
  endtask
  task automatic complete_run;
    $display("compared %0d, mismatched %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    #(95000 * 100);
    mismatches++;
    complete_run;
  end
  initial begin
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    t_reset;
    t_regs;
    t_divs;
    t_select;
    t_count;
    t_route;
    complete_run;
  end
endmodule // tpsc_top_tb_top
